// ==== rtl/ecv_pkg.sv ====
// Package holding constants and carrier types of the exception cause and vectoring unit.
package ecv_pkg;

	localparam logic [31:0] ECV_VEC_EXT_INT = 32'h0000_0500;
	localparam logic [31:0] ECV_VEC_ALIGN = 32'h0000_0600;
	localparam logic [31:0] ECV_VEC_PROGRAM = 32'h0000_0700;
	localparam logic [31:0] ECV_VEC_FP_UNAVAIL = 32'h0000_0800;
	localparam logic [31:0] ECV_TABLE_BASE_HIGH = 32'hFFF0_0000;
	localparam logic [31:0] ECV_TABLE_BASE_LOW = 32'h0000_0000;

	// Cause bit positions in the save/restore status word, bit 0 being the least significant.
	localparam int ECV_SRR_FP_ENABLED_POS = 20;
	localparam int ECV_SRR_ILLEGAL_POS = 19;
	localparam int ECV_SRR_PRIVILEGED_POS = 18;
	localparam int ECV_SRR_TRAP_POS = 17;
	localparam logic [31:0] ECV_SRR_RESET = 32'h0000_0000;

	localparam logic [1:0] ECV_WORD_ALIGNED = 2'h0;
	localparam logic ECV_FEX_RESET = 1'h0;

	typedef enum logic [2:0] {
		ECV_CLASS_NONE,
		ECV_CLASS_EXT_INT,
		ECV_CLASS_ALIGN,
		ECV_CLASS_PROGRAM,
		ECV_CLASS_FP_UNAVAIL
	} ecv_class_e;

	// Machine state register bits that steer exception detection and the vector table base.
	typedef struct packed {
		logic userPrivilegeBit;
		logic fpAvailableBit;
		logic fpExceptionMode0;
		logic fpExceptionMode1;
		logic extIntEnable;
		logic tableBaseHigh;
	} ecv_msr_s;

	// Decoded facts about the instruction that is completing this cycle.
	typedef struct packed {
		logic valid;
		logic isFpOp;
		logic isFpLoadStore;
		logic isLoadStoreMultiple;
		logic isReserveOrConditional;
		logic isCacheBlockZero;
		logic isExtControlWord;
		logic [1:0] effAddrLow;
		logic pageCachingInhibited;
		logic pageWriteThrough;
		logic dcacheLockedOrDisabled;
		logic illegalOpcode;
		logic illegalExtCombo;
		logic unimplementedOptional;
		logic optionalAsNop;
		logic isPrivileged;
		logic isSprMove;
		logic specialRegisterFieldInvalid;
		logic specialRegisterFieldTop;
		logic isTrap;
		logic trapConditionMet;
		logic fpEnabledExcRaised;
		logic isMoveToFpStatus;
		logic [7:0] fpStatusExcBits;
		logic [7:0] fpStatusEnableBits;
	} ecv_insn_s;

endpackage

// ==== rtl/ecv_exception_unit.sv ====
// Exception detection, prioritising and vectoring for the core's completion stage.
`timescale 1ns/1ps

module ecv_exception_unit (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic extIntReqN,
	input wire logic dispatchedEmpty,
	input wire ecv_pkg::ecv_msr_s machineStateReg,
	input wire ecv_pkg::ecv_insn_s cmplInsn,
	output logic dispatchHold,
	output logic fetchRedirect,
	output logic [31:0] handlerAddr,
	output logic [31:0] saveRestoreStatusWord,
	output logic fpEnabledExceptionSummary,
	output ecv_pkg::ecv_class_e excClass
);
	import ecv_pkg::*;

	// Drain is the window between interrupt detection and entry, with dispatch frozen.
	typedef enum {
		ECV_ST_RUN,
		ECV_ST_DRAIN
	} ecv_state_e;

	function automatic logic misaligned(input logic [1:0] low);
		misaligned = (low != ECV_WORD_ALIGNED);
	endfunction

	function automatic logic [31:0] vectorAddr(input logic baseHigh, input logic [31:0] offset);
		vectorAddr = (baseHigh ? ECV_TABLE_BASE_HIGH : ECV_TABLE_BASE_LOW) | offset;
	endfunction

	// Vector offset of each redirect class; a class of none never reaches a redirect.
	function automatic logic [31:0] classOffset(input ecv_class_e cls);
		case (cls)
			ECV_CLASS_EXT_INT: classOffset = ECV_VEC_EXT_INT;
			ECV_CLASS_ALIGN: classOffset = ECV_VEC_ALIGN;
			ECV_CLASS_FP_UNAVAIL: classOffset = ECV_VEC_FP_UNAVAIL;
			default: classOffset = ECV_VEC_PROGRAM;
		endcase
	endfunction

	// Only the highest-priority program cause is recorded, so the handler never sees two reasons at once.
	function automatic logic [31:0] programCauseWord(input logic illegal, input logic priv, input logic trap,
			input logic fpEnabled);
		programCauseWord = ECV_SRR_RESET;
		if (illegal) begin
			programCauseWord[ECV_SRR_ILLEGAL_POS] = 1'h1;
		end else if (priv) begin
			programCauseWord[ECV_SRR_PRIVILEGED_POS] = 1'h1;
		end else if (trap) begin
			programCauseWord[ECV_SRR_TRAP_POS] = 1'h1;
		end else if (fpEnabled) begin
			programCauseWord[ECV_SRR_FP_ENABLED_POS] = 1'h1;
		end
	endfunction

	ecv_state_e state_q, state_d;
	logic dispatchHold_q, dispatchHold_d;
	logic fetchRedirect_q, fetchRedirect_d;
	logic [31:0] handlerAddr_q, handlerAddr_d;
	logic [31:0] srr_q, srr_d;
	logic fex_q, fex_d;
	ecv_class_e excClass_q, excClass_d;

	logic alignExc, illegalExc, privExc, fpUnavailExc, trapExc, fpEnabledExc, programExc;
	logic insnExc;
	logic alignAccess, alignCbzPage, alignCbzCache, alignExtControl;
	logic privInsn, privSprMove;

	// Cause detection on the completing instruction; every cause stands alone so each can be traced.
	always_comb begin
		alignAccess = (cmplInsn.isFpLoadStore || cmplInsn.isLoadStoreMultiple || cmplInsn.isReserveOrConditional)
			&& misaligned(cmplInsn.effAddrLow);
		alignCbzPage = cmplInsn.isCacheBlockZero &&
			(cmplInsn.pageCachingInhibited || cmplInsn.pageWriteThrough);
		alignCbzCache = cmplInsn.isCacheBlockZero && cmplInsn.dcacheLockedOrDisabled;
		alignExtControl = cmplInsn.isExtControlWord && misaligned(cmplInsn.effAddrLow);
		alignExc = cmplInsn.valid && (alignAccess || alignCbzPage || alignCbzCache || alignExtControl);
		// Optional instructions decoded as no-ops complete quietly and so mask the illegal cause.
		illegalExc = cmplInsn.valid && !cmplInsn.optionalAsNop &&
			(cmplInsn.illegalOpcode || cmplInsn.illegalExtCombo || cmplInsn.unimplementedOptional);
		privInsn = cmplInsn.isPrivileged;
		privSprMove = cmplInsn.isSprMove && cmplInsn.specialRegisterFieldInvalid &&
			cmplInsn.specialRegisterFieldTop;
		privExc = cmplInsn.valid && machineStateReg.userPrivilegeBit && (privInsn || privSprMove);
		// Loads, stores and moves of floating-point data need the unit as much as arithmetic does.
		fpUnavailExc = cmplInsn.valid && (cmplInsn.isFpOp || cmplInsn.isFpLoadStore) &&
			!machineStateReg.fpAvailableBit;
		// A trap whose selected comparisons all fail completes as an ordinary instruction.
		trapExc = cmplInsn.valid && cmplInsn.isTrap && cmplInsn.trapConditionMet;
		// Both mode bits clear means floating-point enabled exceptions are ignored.
		fpEnabledExc = cmplInsn.valid && fex_q &&
			(machineStateReg.fpExceptionMode0 || machineStateReg.fpExceptionMode1);
		programExc = illegalExc || privExc || trapExc || fpEnabledExc;
		insnExc = alignExc || programExc || fpUnavailExc;
	end

	// Summary bit: an enabled FP exception sets it; a status move recomputes it.
	always_comb begin
		fex_d = fex_q;
		if (cmplInsn.valid && cmplInsn.isMoveToFpStatus) begin
			fex_d = |(cmplInsn.fpStatusExcBits & cmplInsn.fpStatusEnableBits);
		end
		if (cmplInsn.valid && cmplInsn.fpEnabledExcRaised) begin
			fex_d = 1'h1;
		end
	end

	// The summary bit survives exception entry; only a status move or reset can clear it.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			fex_q <= ECV_FEX_RESET;
		end else begin
			fex_q <= fex_d;
		end
	end

	// Exception selection, dispatch hold and handler redirect.
	always_comb begin
		// Redirect and class are one-cycle pulses; address and cause word hold until the next redirect.
		state_d = state_q;
		dispatchHold_d = dispatchHold_q;
		fetchRedirect_d = 1'h0;
		handlerAddr_d = handlerAddr_q;
		srr_d = srr_q;
		excClass_d = ECV_CLASS_NONE;
		if (insnExc) begin
			// Instruction exceptions win over a pending interrupt; the drain restarts afterwards.
			fetchRedirect_d = 1'h1;
			state_d = ECV_ST_RUN;
			dispatchHold_d = 1'h0;
			// Causes that stop an instruction from executing outrank those that it raises by executing.
			if (illegalExc || privExc) begin
				excClass_d = ECV_CLASS_PROGRAM;
			end else if (fpUnavailExc) begin
				excClass_d = ECV_CLASS_FP_UNAVAIL;
			end else if (alignExc) begin
				excClass_d = ECV_CLASS_ALIGN;
			end else begin
				excClass_d = ECV_CLASS_PROGRAM;
			end
			handlerAddr_d = vectorAddr(machineStateReg.tableBaseHigh, classOffset(excClass_d));
			srr_d = ECV_SRR_RESET;
			if (excClass_d == ECV_CLASS_PROGRAM) begin
				srr_d = programCauseWord(illegalExc, privExc, trapExc, fpEnabledExc);
			end
		end else begin
			unique case (state_q)
				ECV_ST_RUN: begin
					// Dispatch stops at once; entry itself waits until the dispatched window has drained.
					if (!extIntReqN && machineStateReg.extIntEnable) begin
						state_d = ECV_ST_DRAIN;
						dispatchHold_d = 1'h1;
					end
				end
				ECV_ST_DRAIN: begin
					if (extIntReqN) begin
						// A withdrawn request is dropped rather than serviced late.
						state_d = ECV_ST_RUN;
						dispatchHold_d = 1'h0;
					end else if (dispatchedEmpty && !cmplInsn.valid) begin
						// Nothing in flight and nothing completing, so entry cannot overtake an older exception.
						state_d = ECV_ST_RUN;
						dispatchHold_d = 1'h0;
						fetchRedirect_d = 1'h1;
						handlerAddr_d = vectorAddr(machineStateReg.tableBaseHigh, ECV_VEC_EXT_INT);
						srr_d = ECV_SRR_RESET;
						excClass_d = ECV_CLASS_EXT_INT;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_q <= ECV_ST_RUN;
			dispatchHold_q <= 1'h0;
			fetchRedirect_q <= 1'h0;
			// The handler address resets to the low table base and means nothing until the first redirect.
			handlerAddr_q <= ECV_TABLE_BASE_LOW;
			srr_q <= ECV_SRR_RESET;
			excClass_q <= ECV_CLASS_NONE;
		end else begin
			state_q <= state_d;
			dispatchHold_q <= dispatchHold_d;
			fetchRedirect_q <= fetchRedirect_d;
			handlerAddr_q <= handlerAddr_d;
			srr_q <= srr_d;
			excClass_q <= excClass_d;
		end
	end

	// Every output is a register copy, so nothing combinational leaves the block.
	assign dispatchHold = dispatchHold_q;
	assign fetchRedirect = fetchRedirect_q;
	assign handlerAddr = handlerAddr_q;
	assign saveRestoreStatusWord = srr_q;
	assign fpEnabledExceptionSummary = fex_q;
	assign excClass = excClass_q;

endmodule

// ==== tb/ecv_exception_unit_props.sv ====
// Port-level assertions for the exception unit.
`timescale 1ns/1ps
module ecv_exception_unit_props (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic extIntReqN,
	input wire logic dispatchedEmpty,
	input wire ecv_pkg::ecv_msr_s machineStateReg,
	input wire ecv_pkg::ecv_insn_s cmplInsn,
	input wire logic dispatchHold,
	input wire logic fetchRedirect,
	input wire logic [31:0] handlerAddr,
	input wire logic [31:0] saveRestoreStatusWord,
	input wire logic fpEnabledExceptionSummary,
	input wire ecv_pkg::ecv_class_e excClass
);
	import ecv_pkg::*;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (reset);
	AST_VEC_EXT: assert property (excClass == ECV_CLASS_EXT_INT |-> handlerAddr[19:0] == 20'h00500)
		else $error("ext vector");
	AST_VEC_ALN: assert property (excClass == ECV_CLASS_ALIGN |-> handlerAddr[19:0] == 20'h00600)
		else $error("align vector");
	AST_VEC_PRG: assert property (excClass == ECV_CLASS_PROGRAM |-> handlerAddr[19:0] == 20'h00700)
		else $error("program vector");
	AST_VEC_FPU: assert property (excClass == ECV_CLASS_FP_UNAVAIL |-> handlerAddr[19:0] == 20'h00800)
		else $error("fp unavailable vector");
	AST_BASE: assert property (fetchRedirect |-> handlerAddr[31:20] ==
		($past(machineStateReg.tableBaseHigh) ? 12'hFFF : 12'h000)) else $error("table base");
	AST_INT_ORDER: assert property (excClass == ECV_CLASS_EXT_INT |->
		$past(dispatchedEmpty) && !$past(cmplInsn.valid)) else $error("interrupt taken early");
	AST_HOLD: assert property ($rose(dispatchHold) |-> !$past(extIntReqN)) else $error("hold cause");
	AST_SRR: assert property (fetchRedirect |->
		(excClass == ECV_CLASS_PROGRAM) == $onehot(saveRestoreStatusWord[20:17])) else $error("cause bits");
	AST_SUM: assert property (cmplInsn.valid && cmplInsn.isMoveToFpStatus && !cmplInsn.fpEnabledExcRaised |=>
		fpEnabledExceptionSummary == |($past(cmplInsn.fpStatusExcBits) & $past(cmplInsn.fpStatusEnableBits)))
		else $error("summary bit");
endmodule
bind ecv_exception_unit ecv_exception_unit_props props (.*);

// ==== tb/ecv_int_src.sv ====
// Behavioural interrupt source that holds its request until the handler starts.
`timescale 1ns/1ps
module ecv_int_src (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic fire,
	input wire logic fetchRedirect,
	input wire ecv_pkg::ecv_class_e excClass,
	output logic extIntReqN
);
	import ecv_pkg::*;
	logic goSeen;
	logic doneSeen;
	initial extIntReqN = 1'h1;
	always @(posedge sys_clk) begin
		goSeen = fire;
		doneSeen = fetchRedirect && excClass == ECV_CLASS_EXT_INT;
		#1;
		if (reset || doneSeen) extIntReqN = 1'h1;
		else if (goSeen) extIntReqN = 1'h0;
	end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the exception unit.
`timescale 1ns/1ps
module tb_top;
	import ecv_pkg::*;
	logic sys_clk = 1'h0;
	logic reset = 1'h1;
	logic dispatchedEmpty = 1'h1;
	logic fire = 1'h0;
	ecv_msr_s machineStateReg = '0;
	ecv_insn_s cmplInsn = '0;
	logic extIntReqN, dispatchHold, fetchRedirect, fpEnabledExceptionSummary;
	logic [31:0] handlerAddr, saveRestoreStatusWord;
	ecv_class_e excClass;
	int n_mismatch = 0, checked = 0, n;
	logic [31:0] seed = 32'h0559;
	ecv_exception_unit dut (
		.sys_clk(sys_clk),
		.reset(reset),
		.extIntReqN(extIntReqN),
		.dispatchedEmpty(dispatchedEmpty),
		.machineStateReg(machineStateReg),
		.cmplInsn(cmplInsn),
		.dispatchHold(dispatchHold),
		.fetchRedirect(fetchRedirect),
		.handlerAddr(handlerAddr),
		.saveRestoreStatusWord(saveRestoreStatusWord),
		.fpEnabledExceptionSummary(fpEnabledExceptionSummary),
		.excClass(excClass)
	);
	ecv_int_src src (
		.sys_clk(sys_clk),
		.reset(reset),
		.fire(fire),
		.fetchRedirect(fetchRedirect),
		.excClass(excClass),
		.extIntReqN(extIntReqN)
	);
	initial forever #50 sys_clk = ~sys_clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic step();
		@(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("mismatches %0d, checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	function automatic ecv_insn_s mk(int k);
		ecv_insn_s i;
		i = '0;
		i.valid = 1'h1;
		case (k)
			0: {i.isFpOp, i.isFpLoadStore} = 2'h3;
			1: i.isLoadStoreMultiple = 1'h1;
			2: i.isReserveOrConditional = 1'h1;
			3: {i.isCacheBlockZero, i.pageCachingInhibited} = 2'h3;
			4: {i.isCacheBlockZero, i.pageWriteThrough} = 2'h3;
			5: {i.isCacheBlockZero, i.dcacheLockedOrDisabled} = 2'h3;
			6: i.isExtControlWord = 1'h1;
			7: i.illegalOpcode = 1'h1;
			8: i.illegalExtCombo = 1'h1;
			9: i.unimplementedOptional = 1'h1;
			10: i.isPrivileged = 1'h1;
			11: {i.isSprMove, i.specialRegisterFieldInvalid, i.specialRegisterFieldTop} = 3'h7;
			12: {i.isTrap, i.trapConditionMet} = 2'h3;
			13: i.isFpOp = 1'h1;
			14: {i.unimplementedOptional, i.optionalAsNop} = 2'h3;
			default: i.isTrap = 1'h1;
		endcase
		// Only accesses whose alignment matters get a misaligned address, so causes stay isolated.
		if (k < 3 || k == 6) i.effAddrLow = 2'h1 + 2'(rnd() % 3);
		return i;
	endfunction
	task automatic go(input ecv_insn_s i, input ecv_class_e c, input int pos);
		cmplInsn = i;
		step();
		chk(fetchRedirect, c != ECV_CLASS_NONE);
		chk(excClass, c);
		// The vector offset of class c sits in bits 11:8 as 4 plus the class code.
		if (c != ECV_CLASS_NONE) chk(handlerAddr, (machineStateReg.tableBaseHigh ? 32'hFFF00000 : 32'h0) |
			{20'h00000, 4'h4 + 4'(c), 8'h00});
		if (c != ECV_CLASS_NONE) chk(saveRestoreStatusWord, pos < 0 ? 32'h0 : 32'h1 << pos);
	endtask
	initial begin
		int k, j;
		ecv_insn_s m;
		repeat (8) step();
		chk(handlerAddr, 32'h0);
		chk(fpEnabledExceptionSummary, 1'h0);
		reset = 1'h0;
		machineStateReg.userPrivilegeBit = 1'h1;
		for (k = 0; k < 32; k++) begin
			j = k % 16;
			machineStateReg.tableBaseHigh = 1'(rnd());
			machineStateReg.fpAvailableBit = j != 13;
			go(mk(j), j < 7 ? ECV_CLASS_ALIGN : j < 13 ? ECV_CLASS_PROGRAM : j == 13 ? ECV_CLASS_FP_UNAVAIL :
				ECV_CLASS_NONE, j < 7 || j > 12 ? -1 : j < 10 ? 19 : j < 12 ? 18 : 17);
		end
		cmplInsn = '0;
		machineStateReg = '0;
		machineStateReg.extIntEnable = 1'h1;
		dispatchedEmpty = 1'h0;
		fire = 1'h1;
		step();
		fire = 1'h0;
		repeat (4) step();
		chk(dispatchHold, 1'h1);
		chk(fetchRedirect, 1'h0);
		go(mk(1), ECV_CLASS_ALIGN, -1);
		cmplInsn = '0;
		dispatchedEmpty = 1'h1;
		// The alignment redirect is still standing here, so wait for the interrupt class itself.
		for (n = 0; n < 20 && excClass !== ECV_CLASS_EXT_INT; n++) step();
		if (n == 20) begin
			n_mismatch++;
			wrap_up();
		end
		// Handler software masks the source, otherwise the still-held request opens a new drain until it is withdrawn.
		machineStateReg.extIntEnable = 1'h0;
		chk(excClass, ECV_CLASS_EXT_INT);
		chk(fetchRedirect, 1'h1);
		chk(dispatchHold, 1'h0);
		chk(handlerAddr, 32'h00000500);
		chk(saveRestoreStatusWord, 32'h0);
		m = '0;
		m.valid = 1'h1;
		m.isMoveToFpStatus = 1'h1;
		for (n = 0; n < 6; n++) begin
			m.fpStatusExcBits = n == 5 ? 8'h0F : 8'(rnd());
			m.fpStatusEnableBits = n == 5 ? 8'hF0 : 8'(rnd());
			go(m, ECV_CLASS_NONE, -1);
			chk(fpEnabledExceptionSummary, |(m.fpStatusExcBits & m.fpStatusEnableBits));
		end
		machineStateReg.fpAvailableBit = 1'h1;
		m = mk(13);
		m.fpEnabledExcRaised = 1'h1;
		go(m, ECV_CLASS_NONE, -1);
		chk(fpEnabledExceptionSummary, 1'h1);
		m.fpEnabledExcRaised = 1'h0;
		machineStateReg.fpExceptionMode0 = 1'h1;
		go(m, ECV_CLASS_PROGRAM, 20);
		{machineStateReg.fpExceptionMode0, machineStateReg.fpExceptionMode1} = 2'h1;
		go(m, ECV_CLASS_PROGRAM, 20);
		cmplInsn = '0;
		reset = 1'h1;
		step();
		chk(fpEnabledExceptionSummary, 1'h0);
		chk(handlerAddr, 32'h0);
		wrap_up();
	end
endmodule
